//--- nvc_ctrl.sv
// Nested vectored interrupt controller: pending/enable/priority/active state,
// arbitration, and the entry, tail-chain and return sequencing with the core.
// Assumes the core performs stack pushes, pops and vector reads on request.
`timescale 1ns/1ns
`include "nvc_map.svh"

// Behaviour
// - Thirty-two request lines, four priority levels
// - Priority zero most urgent, three least
// - All configurable priorities reset to zero
// - NMI, hard fault fixed above level zero
// - Supervisor call, pendable service, tick programmable
// - Strictly more urgent request pre-empts handler
// - Accepted exceptions run in handler mode
// - Hardware reads handler address from vector table
// - Core state pushed during vector fetch
// - Handler end pops state and resumes
// - Pending request at end tail-chains directly
// - Late urgent arrival replaces entry without delay
// - Vector table fixed at address zero
// - Lines zero to 31 map to vectors 16-47
// - Line 0 brown-out, line 1 watchdog
// - Lines 2 and 3 external pin requests
// - Lines 4 and 5 collect port changes
// - Line 28 wake, 29 converter, timers 8-11
// - Registers respond from 0xE000_E100 onward
// - Write-one set and clear, both read state
// - Disabled line pends only; active stays active
// - Clearing pending leaves active handler alone
// - Priority in 8-bit field, four per word
module nvc_ctrl (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 nrst_i,
  // Register port
  input  wire nvc_pkg::nvc_bus_req_t bus_i,
  output logic [31:0]               rdata_o,
  // Interrupt sources
  input  wire nvc_pkg::nvc_irq_src_t irq_src_i,
  input  wire nvc_pkg::nvc_sys_exc_t sys_exc_i,
  // Core sequencing
  input  wire nvc_pkg::nvc_core_in_t core_i,
  output logic                      push_req_o,
  output logic                      pop_req_o,
  output logic                      vfetch_req_o,
  output logic [31:0]               vfetch_addr_o,
  output logic                      enter_o,
  output logic [31:0]               handler_pc_o,
  output logic [5:0]                exc_num_o,
  output logic                      handler_mode_o
);

  nvc_pkg::nvc_state_t state_r;
  logic [31:0]         line_w;
  logic [31:0]         en_r;
  logic [47:0]         pend_r;
  logic [47:0]         act_r;
  logic [1:0]          irq_pri_r [`NVC_NUM_IRQ];
  logic [1:0]          svc_pri_r;
  logic [1:0]          pservc_pri_r;
  logic [1:0]          tick_pri_r;
  logic [2:0]          rank_w [`NVC_NUM_VEC];
  logic [47:0]         req_w;
  logic [47:0]         hw_set_w;
  logic [47:0]         sw_set_w;
  logic [47:0]         sw_clr_w;
  logic [2:0]          best_rank_w;
  logic [5:0]          best_vec_w;
  logic [2:0]          cur_rank_w;
  logic [5:0]          cur_vec_w;
  logic [5:0]          sel_vec_r;
  logic [2:0]          sel_rank_r;
  logic                push_ok_r;
  logic                vec_ok_r;
  logic [31:0]         vdata_r;
  logic                late_w;
  logic                push_now_w;
  logic                vec_now_w;
  logic                take_w;
  logic                wr_set_en_w;
  logic                wr_clr_en_w;
  logic                wr_set_pend_w;
  logic                wr_clr_pend_w;
  logic                wr_pri_w;
  logic                wr_sys_pri_w;
  logic [2:0]          pri_idx_w;
  logic [31:0]         rd_nxt;
  // Named copy so single mask bits can be selected
  localparam logic [31:0] RSV_MASK = `NVC_RESERVED_LINES;

  // Named sources onto numbered lines; reserved positions stay zero
  always_comb begin
    line_w      = 32'h0000_0000;
    line_w[0]   = irq_src_i.brownout_irq;
    line_w[1]   = irq_src_i.watchdog_irq;
    line_w[2]   = irq_src_i.ext_pin_irq_a;
    line_w[3]   = irq_src_i.ext_pin_irq_b;
    line_w[4]   = irq_src_i.port_ab_irq;
    line_w[5]   = irq_src_i.port_cdf_irq;
    line_w[6]   = irq_src_i.pulse_width_irq;
    line_w[11:8] = irq_src_i.timer_irq;
    line_w[13:12] = irq_src_i.serial_port_irq;
    line_w[16:14] = irq_src_i.sync_serial_irq;
    line_w[19:18] = irq_src_i.two_wire_irq;
    line_w[23]  = irq_src_i.usb_dev_irq;
    line_w[24]  = irq_src_i.keyboard_port_irq;
    line_w[26]  = irq_src_i.periph_dma_irq;
    line_w[27]  = irq_src_i.audio_serial_irq;
    line_w[28]  = irq_src_i.power_wake_irq;
    line_w[29]  = irq_src_i.converter_irq;
  end

  // Register decode
  assign wr_set_en_w   = bus_i.wr && (bus_i.addr == `NVC_ADDR_SET_EN);
  assign wr_clr_en_w   = bus_i.wr && (bus_i.addr == `NVC_ADDR_CLR_EN);
  assign wr_set_pend_w = bus_i.wr && (bus_i.addr == `NVC_ADDR_SET_PEND);
  assign wr_clr_pend_w = bus_i.wr && (bus_i.addr == `NVC_ADDR_CLR_PEND);
  assign wr_sys_pri_w  = bus_i.wr && (bus_i.addr == `NVC_ADDR_SYS_PRI);
  assign wr_pri_w      = bus_i.wr && (bus_i.addr >= `NVC_ADDR_PRI_BASE) &&
                         (bus_i.addr <= `NVC_ADDR_PRI_LAST) && (bus_i.addr[1:0] == 2'h0);
  assign pri_idx_w     = bus_i.addr[4:2];

  // Per-vector rank, request and set/clear terms
  genvar v;
  generate
    for (v = 0; v < `NVC_NUM_VEC; v++) begin : g_vec
      if (v >= 16) begin : g_irq
        // Fixed levels sit above every configurable level
        assign rank_w[v]   = `NVC_RANK_CFG_BASE + {1'b0, irq_pri_r[v-16]};
        assign req_w[v]    = pend_r[v] && en_r[v-16];
        assign hw_set_w[v] = line_w[v-16] && !RSV_MASK[v-16];
        assign sw_set_w[v] = wr_set_pend_w && bus_i.wdata[v-16] && !RSV_MASK[v-16];
        assign sw_clr_w[v] = wr_clr_pend_w && bus_i.wdata[v-16];
      end else begin : g_sys
        assign rank_w[v]   = (v == 2)  ? `NVC_RANK_NMI :
                             (v == 3)  ? `NVC_RANK_HARDF :
                             (v == 11) ? `NVC_RANK_CFG_BASE + {1'b0, svc_pri_r} :
                             (v == 14) ? `NVC_RANK_CFG_BASE + {1'b0, pservc_pri_r} :
                                         `NVC_RANK_CFG_BASE + {1'b0, tick_pri_r};
        assign req_w[v]    = pend_r[v];
        assign hw_set_w[v] = (v == 2)  ? sys_exc_i.nmi :
                             (v == 3)  ? sys_exc_i.hard_fault :
                             (v == 11) ? sys_exc_i.supervisor_call_exc :
                             (v == 14) ? sys_exc_i.pendable_service_exc :
                             (v == 15) ? sys_exc_i.system_tick_exc : 1'b0;
        assign sw_set_w[v] = 1'b0;
        assign sw_clr_w[v] = 1'b0;
      end
    end
  endgenerate

  // Most urgent request; ties go to the lower vector
  always_comb begin
    best_rank_w = `NVC_RANK_THREAD;
    best_vec_w  = `NVC_VEC_NONE;
    cur_rank_w  = `NVC_RANK_THREAD;
    cur_vec_w   = `NVC_VEC_NONE;
    for (int i = 0; i < `NVC_NUM_VEC; i++) begin
      if (req_w[i] && !act_r[i] && (rank_w[i] < best_rank_w)) begin
        best_rank_w = rank_w[i];
        best_vec_w  = 6'(i);
      end
      if (act_r[i] && (rank_w[i] < cur_rank_w)) begin
        cur_rank_w = rank_w[i];
        cur_vec_w  = 6'(i);
      end
    end
  end

  // Sequencing helpers
  assign late_w     = ((state_r == nvc_pkg::NVC_STACK) || (state_r == nvc_pkg::NVC_FETCH)) &&
                      (best_rank_w < sel_rank_r);
  assign push_now_w = (state_r == nvc_pkg::NVC_FETCH) || push_ok_r || core_i.push_done;
  assign vec_now_w  = !late_w && (vec_ok_r || (vfetch_req_o && core_i.vfetch_ack));
  assign take_w     = ((state_r == nvc_pkg::NVC_STACK) || (state_r == nvc_pkg::NVC_FETCH)) &&
                      push_now_w && vec_now_w;

  // Main sequencer
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r       <= nvc_pkg::NVC_IDLE;
      sel_vec_r     <= `NVC_VEC_NONE;
      sel_rank_r    <= `NVC_RANK_THREAD;
      push_ok_r     <= 1'b0;
      vec_ok_r      <= 1'b0;
      vdata_r       <= `NVC_RST_WORD;
      push_req_o    <= 1'b0;
      pop_req_o     <= 1'b0;
      vfetch_req_o  <= 1'b0;
      vfetch_addr_o <= `NVC_VTAB_BASE;
      enter_o       <= 1'b0;
      handler_pc_o  <= `NVC_RST_WORD;
      exc_num_o     <= `NVC_VEC_NONE;
    end else begin
      enter_o <= take_w;
      case (state_r)
        nvc_pkg::NVC_IDLE: begin
          if (core_i.exc_return && (act_r != 48'h0)) begin
            state_r <= nvc_pkg::NVC_RET;
          end else if (best_rank_w < cur_rank_w) begin
            state_r       <= nvc_pkg::NVC_STACK;
            sel_vec_r     <= best_vec_w;
            sel_rank_r    <= best_rank_w;
            push_ok_r     <= 1'b0;
            vec_ok_r      <= 1'b0;
            push_req_o    <= 1'b1;
            vfetch_req_o  <= 1'b1;
            vfetch_addr_o <= `NVC_VTAB_BASE + {24'h00_0000, best_vec_w, 2'b00};
          end
        end
        nvc_pkg::NVC_STACK, nvc_pkg::NVC_FETCH: begin
          if (core_i.push_done) begin
            push_ok_r  <= 1'b1;
            push_req_o <= 1'b0;
          end
          if (late_w) begin
            // Stacking continues; only the vector read restarts
            sel_vec_r     <= best_vec_w;
            sel_rank_r    <= best_rank_w;
            vec_ok_r      <= 1'b0;
            vfetch_req_o  <= 1'b1;
            vfetch_addr_o <= `NVC_VTAB_BASE + {24'h00_0000, best_vec_w, 2'b00};
          end else if (vfetch_req_o && core_i.vfetch_ack) begin
            vec_ok_r     <= 1'b1;
            vfetch_req_o <= 1'b0;
            vdata_r      <= core_i.vfetch_data;
          end
          if (take_w) begin
            state_r      <= nvc_pkg::NVC_IDLE;
            push_req_o   <= 1'b0;
            vfetch_req_o <= 1'b0;
            handler_pc_o <= vec_ok_r ? vdata_r : core_i.vfetch_data;
            exc_num_o    <= sel_vec_r;
            sel_rank_r   <= `NVC_RANK_THREAD;
          end
        end
        nvc_pkg::NVC_RET: begin
          if (best_rank_w < cur_rank_w) begin
            state_r       <= nvc_pkg::NVC_FETCH;
            sel_vec_r     <= best_vec_w;
            sel_rank_r    <= best_rank_w;
            vec_ok_r      <= 1'b0;
            vfetch_req_o  <= 1'b1;
            vfetch_addr_o <= `NVC_VTAB_BASE + {24'h00_0000, best_vec_w, 2'b00};
          end else begin
            state_r   <= nvc_pkg::NVC_UNSTACK;
            pop_req_o <= 1'b1;
          end
        end
        nvc_pkg::NVC_UNSTACK: begin
          if (core_i.pop_done) begin
            state_r   <= nvc_pkg::NVC_IDLE;
            pop_req_o <= 1'b0;
            exc_num_o <= cur_vec_w;
          end
        end
        default: begin
          state_r <= nvc_pkg::NVC_IDLE;
        end
      endcase
    end
  end

  // Pending state; a set in the same cycle beats a clear
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_r <= 48'h0000_0000_0000;
    end else begin
      for (int i = 0; i < `NVC_NUM_VEC; i++) begin
        if (hw_set_w[i] || sw_set_w[i]) begin
          pend_r[i] <= 1'b1;
        end else if (sw_clr_w[i] || (take_w && (sel_vec_r == 6'(i)))) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  // Enable state
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_r <= `NVC_RST_WORD;
    end else if (wr_set_en_w) begin
      en_r <= en_r | bus_i.wdata;
    end else if (wr_clr_en_w) begin
      en_r <= en_r & ~bus_i.wdata;
    end
  end

  // Active state; cleared only by return or reset
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_r <= 48'h0000_0000_0000;
    end else begin
      for (int i = 0; i < `NVC_NUM_VEC; i++) begin
        if (take_w && (sel_vec_r == 6'(i))) begin
          act_r[i] <= 1'b1;
        end else if ((state_r == nvc_pkg::NVC_IDLE) && core_i.exc_return && (cur_vec_w == 6'(i))) begin
          act_r[i] <= 1'b0;
        end
      end
    end
  end

  // Handler mode whenever any exception is active
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      handler_mode_o <= 1'b0;
    end else begin
      handler_mode_o <= take_w || ((act_r != 48'h0) && (state_r != nvc_pkg::NVC_UNSTACK)) ||
                        ((state_r == nvc_pkg::NVC_UNSTACK) && (act_r != 48'h0));
    end
  end

  // Priorities: two live bits at the top of each byte
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int k = 0; k < `NVC_NUM_IRQ; k++) begin
        irq_pri_r[k] <= `NVC_RST_PRI;
      end
      svc_pri_r    <= `NVC_RST_PRI;
      pservc_pri_r <= `NVC_RST_PRI;
      tick_pri_r   <= `NVC_RST_PRI;
    end else begin
      if (wr_pri_w) begin
        for (int k = 0; k < `NVC_NUM_IRQ; k++) begin
          if (pri_idx_w == 3'(k / 4)) begin
            irq_pri_r[k] <= bus_i.wdata[8*(k%4)+`NVC_PRI_LSB +: 2];
          end
        end
      end
      if (wr_sys_pri_w) begin
        svc_pri_r    <= bus_i.wdata[`NVC_SYS_PRI_SVC +: 2];
        pservc_pri_r <= bus_i.wdata[`NVC_SYS_PRI_PSERVC +: 2];
        tick_pri_r   <= bus_i.wdata[`NVC_SYS_PRI_TICK +: 2];
      end
    end
  end

  // Read mux; reserved pending bits and unmapped addresses read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if ((bus_i.addr == `NVC_ADDR_SET_EN) || (bus_i.addr == `NVC_ADDR_CLR_EN)) begin
      rd_nxt = en_r;
    end else if ((bus_i.addr == `NVC_ADDR_SET_PEND) || (bus_i.addr == `NVC_ADDR_CLR_PEND)) begin
      rd_nxt = pend_r[47:16];
    end else if (bus_i.addr == `NVC_ADDR_ACTIVE) begin
      rd_nxt = act_r[47:16];
    end else if (bus_i.addr == `NVC_ADDR_STATUS) begin
      rd_nxt = {23'h00_0000, state_r, cur_vec_w};
    end else if (bus_i.addr == `NVC_ADDR_SYS_PRI) begin
      rd_nxt[`NVC_SYS_PRI_SVC +: 2]    = svc_pri_r;
      rd_nxt[`NVC_SYS_PRI_PSERVC +: 2] = pservc_pri_r;
      rd_nxt[`NVC_SYS_PRI_TICK +: 2]   = tick_pri_r;
    end else if ((bus_i.addr >= `NVC_ADDR_PRI_BASE) && (bus_i.addr <= `NVC_ADDR_PRI_LAST) &&
                 (bus_i.addr[1:0] == 2'h0)) begin
      for (int k = 0; k < `NVC_NUM_IRQ; k++) begin
        if (pri_idx_w == 3'(k / 4)) begin
          rd_nxt[8*(k%4)+`NVC_PRI_LSB +: 2] = irq_pri_r[k];
        end
      end
    end
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= `NVC_RST_WORD;
    end else begin
      rdata_o <= bus_i.rd ? rd_nxt : `NVC_RST_WORD;
    end
  end

endmodule

//--- nvc_map.svh
// Address map, field positions, reset values and fixed ranks of the interrupt controller.
// Assumes a 32-bit byte address from the core; vector table sits at a fixed base.
`ifndef NVC_MAP_SVH
`define NVC_MAP_SVH

// Register addresses
`define NVC_ADDR_SET_EN     32'hE000_E100
`define NVC_ADDR_CLR_EN     32'hE000_E180
`define NVC_ADDR_SET_PEND   32'hE000_E200
`define NVC_ADDR_CLR_PEND   32'hE000_E280
`define NVC_ADDR_ACTIVE     32'hE000_E300
`define NVC_ADDR_STATUS     32'hE000_E304
`define NVC_ADDR_PRI_BASE   32'hE000_E400
`define NVC_ADDR_PRI_LAST   32'hE000_E41C
`define NVC_ADDR_SYS_PRI    32'hE000_E500

// Field layout
`define NVC_PRI_LSB         6
`define NVC_SYS_PRI_SVC     6
`define NVC_SYS_PRI_PSERVC  14
`define NVC_SYS_PRI_TICK    22

// Reset values
`define NVC_RST_WORD        32'h0000_0000
`define NVC_RST_PRI         2'h0
`define NVC_RESERVED_LINES  32'hC272_0080

// Ranks: lower is more urgent
`define NVC_RANK_NMI        3'h1
`define NVC_RANK_HARDF      3'h2
`define NVC_RANK_CFG_BASE   3'h3
`define NVC_RANK_THREAD     3'h7

// Vector numbers
`define NVC_VEC_NONE        6'h00
`define NVC_VEC_NMI         6'h02
`define NVC_VEC_HARDF       6'h03
`define NVC_VEC_SVC         6'h0B
`define NVC_VEC_PSERVC      6'h0E
`define NVC_VEC_TICK        6'h0F
`define NVC_VEC_IRQ0        6'h10
`define NVC_NUM_VEC         48
`define NVC_NUM_IRQ         32

// Vector table
`define NVC_VTAB_BASE       32'h0000_0000

`endif

//--- nvc_pkg.sv
// Types shared by the interrupt controller and its surroundings.
// Assumes nvc_map.svh supplies all numeric constants.
package nvc_pkg;

  typedef enum logic [2:0] {
    NVC_IDLE    = 3'b000,
    NVC_STACK   = 3'b001,
    NVC_FETCH   = 3'b010,
    NVC_RET     = 3'b011,
    NVC_UNSTACK = 3'b100
  } nvc_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } nvc_bus_req_t;

  typedef struct packed {
    logic        push_done;
    logic        pop_done;
    logic        vfetch_ack;
    logic [31:0] vfetch_data;
    logic        exc_return;
  } nvc_core_in_t;

  typedef struct packed {
    logic       nmi;
    logic       hard_fault;
    logic       supervisor_call_exc;
    logic       pendable_service_exc;
    logic       system_tick_exc;
  } nvc_sys_exc_t;

  typedef struct packed {
    logic       brownout_irq;
    logic       watchdog_irq;
    logic       ext_pin_irq_a;
    logic       ext_pin_irq_b;
    logic       port_ab_irq;
    logic       port_cdf_irq;
    logic       pulse_width_irq;
    logic [3:0] timer_irq;
    logic [1:0] serial_port_irq;
    logic [2:0] sync_serial_irq;
    logic [1:0] two_wire_irq;
    logic       usb_dev_irq;
    logic       keyboard_port_irq;
    logic       periph_dma_irq;
    logic       audio_serial_irq;
    logic       power_wake_irq;
    logic       converter_irq;
  } nvc_irq_src_t;

endpackage

//--- nvc_ctrl_monitor.sv
// Checker for the interrupt controller's register port and core handshake.
// Assumes it is bound to nvc_ctrl and sees only that module's ports.
`timescale 1ns/1ns
module nvc_ctrl_monitor (
  // Clock and reset
  input wire logic                  mclk_i,
  input wire logic                  nrst_i,
  // Register port
  input wire nvc_pkg::nvc_bus_req_t bus_i,
  input wire logic [31:0]           rdata_o,
  // Interrupt sources
  input wire nvc_pkg::nvc_irq_src_t irq_src_i,
  input wire nvc_pkg::nvc_sys_exc_t sys_exc_i,
  // Core link
  input wire nvc_pkg::nvc_core_in_t core_i,
  input wire logic                  push_req_o,
  input wire logic                  pop_req_o,
  input wire logic                  vfetch_req_o,
  input wire logic [31:0]           vfetch_addr_o,
  input wire logic                  enter_o,
  input wire logic [31:0]           handler_pc_o,
  input wire logic [5:0]            exc_num_o,
  input wire logic                  handler_mode_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic [31:0] ack_data_r;

  // Last accepted table word, the only legal jump target
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i)
      ack_data_r <= 32'h0000_0000;
    else if (vfetch_req_o && core_i.vfetch_ack)
      ack_data_r <= core_i.vfetch_data;
  end

  sequence s_fetch_wait;
    vfetch_req_o && !core_i.vfetch_ack;
  endsequence
  sequence s_pop_end;
    pop_req_o && core_i.pop_done;
  endsequence

  a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0000_0000)
    else $error("read data outside the answer cycle");
  a_enter_pulse: assert property (enter_o |=> !enter_o)
    else $error("entry strobe longer than one cycle");
  a_enter_mode: assert property (enter_o |-> handler_mode_o)
    else $error("handler entered outside handler mode");
  a_enter_pc: assert property (enter_o |-> handler_pc_o == ack_data_r)
    else $error("handler address not the fetched table word");
  a_enter_cause: assert property (enter_o |-> $past(core_i.push_done || core_i.vfetch_ack))
    else $error("entry without a finished push or fetch");
  a_fetch_hold: assert property (s_fetch_wait |=> vfetch_req_o)
    else $error("vector fetch dropped before acknowledge");
  a_push_hold: assert property (push_req_o && !core_i.push_done |=> push_req_o)
    else $error("push request dropped early");
  a_pop_hold: assert property (pop_req_o && !core_i.pop_done |=> pop_req_o)
    else $error("pop request dropped early");
  a_pop_release: assert property (s_pop_end |=> !pop_req_o)
    else $error("pop request held after pop done");
  a_vec_table: assert property (vfetch_req_o |-> vfetch_addr_o[1:0] == 2'h0 && vfetch_addr_o < 32'h0000_00C0)
    else $error("vector fetch outside the table");
  a_ret_gap: assert property (core_i.exc_return |=> !pop_req_o && !enter_o)
    else $error("no return cycle after handler end");
endmodule

bind nvc_ctrl nvc_ctrl_monitor u_mon (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .irq_src_i(irq_src_i), .sys_exc_i(sys_exc_i), .core_i(core_i), .push_req_o(push_req_o),
  .pop_req_o(pop_req_o), .vfetch_req_o(vfetch_req_o), .vfetch_addr_o(vfetch_addr_o), .enter_o(enter_o),
  .handler_pc_o(handler_pc_o), .exc_num_o(exc_num_o), .handler_mode_o(handler_mode_o));

//--- nvc_core_model.sv
// Behavioural core: answers push, pop and vector reads after a set delay.
// Assumes level requests that stay up until the matching one-cycle done.
`timescale 1ns/1ns
module nvc_core_model (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // Answer delay in cycles
  input  wire logic [3:0]  dly_i,
  // Requests: vector read, pop, push
  input  wire logic [2:0]  req_i,
  input  wire logic [31:0] vfetch_addr_i,
  // Answers in the same order
  output logic [2:0]       done_o,
  output logic [31:0]      vfetch_data_o
);
  logic [3:0] cnt_r [3];

  // Table at address zero; word off the ack is inverted so stale data never matches
  assign vfetch_data_o = done_o[2] ? 32'h0000_1000 + vfetch_addr_i : ~(32'h0000_1000 + vfetch_addr_i);

  // Stack save, restore and fetch each finish once per request
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    for (int g = 0; g < 3; g++) begin
      if (!nrst_i) begin
        cnt_r[g]  <= 4'h0;
        done_o[g] <= 1'b0;
      end else if (req_i[g] && !done_o[g]) begin
        cnt_r[g]  <= cnt_r[g] + 4'h1;
        done_o[g] <= (cnt_r[g] >= dly_i);
      end else begin
        cnt_r[g]  <= 4'h0;
        done_o[g] <= 1'b0;
      end
    end
  end
endmodule

//--- nvc_tb.sv
// Self-checking bench for the interrupt controller with a behavioural core.
// Assumes nvc_pkg compiled first; the checker is bound from its own file.
`timescale 1ns/1ns
module tb;
  typedef struct {logic [31:0] wa, wd, ra, ex;} nvc_row_t;
  logic                  mclk_i = 1'b0;
  logic                  nrst_i = 1'b0;
  nvc_pkg::nvc_bus_req_t bus = '0;
  nvc_pkg::nvc_irq_src_t irq = '0;
  nvc_pkg::nvc_sys_exc_t sysx = '0;
  nvc_pkg::nvc_core_in_t core;
  logic                  exc_ret = 1'b0;
  logic [3:0]            dly = 4'h1;
  logic [2:0]            done;
  logic [31:0]           vdata, rdata, vaddr, hpc;
  logic                  push, pop, vf, ent, hmode;
  logic [5:0]            exn;
  int                    bad_count = 0, checks = 0, cyc = 0, ent_cnt = 0, push_cnt = 0, c, p;
  int                    line_of [24] = '{29, 28, 27, 26, 24, 23, 18, 19, 14, 15, 16, 12, 13, 8, 9, 10, 11,
                                          6, 5, 4, 3, 2, 1, 0};
  logic [5:0]            sys_vec [4] = '{6'h0F, 6'h0E, 6'h0B, 6'h03};
  logic [31:0]           rst_adr [5] = '{32'hE000_E100, 32'hE000_E200, 32'hE000_E400, 32'hE000_E41C, 32'hE000_E500};
  nvc_row_t              rows [10] = '{
    '{32'hE000_E100, 32'h0000_00FF, 32'hE000_E100, 32'h0000_00FF},
    '{32'hE000_E180, 32'h0000_000F, 32'hE000_E180, 32'h0000_00F0},
    '{32'hE000_E180, 32'hFFFF_FFFF, 32'hE000_E100, 32'h0000_0000},
    '{32'hE000_E200, 32'hFFFF_FFFF, 32'hE000_E200, 32'h3D8D_FF7F},
    '{32'hE000_E280, 32'hFFFF_FFFF, 32'hE000_E200, 32'h0000_0000},
    '{32'hE000_E400, 32'hFFFF_FFFF, 32'hE000_E400, 32'hC0C0_C0C0},
    '{32'hE000_E41C, 32'h4080_C03F, 32'hE000_E41C, 32'h4080_C000},
    '{32'hE000_E500, 32'hFFFF_FFFF, 32'hE000_E500, 32'h00C0_C0C0},
    '{32'hE000_E600, 32'hFFFF_FFFF, 32'hE000_E600, 32'h0000_0000},
    '{32'hE000_E402, 32'hFFFF_FFFF, 32'hE000_E402, 32'h0000_0000}};

  always #20 mclk_i = ~mclk_i;
  assign core = '{done[0], done[1], done[2], vdata, exc_ret};

  nvc_ctrl uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata), .irq_src_i(irq),
    .sys_exc_i(sysx), .core_i(core), .push_req_o(push), .pop_req_o(pop), .vfetch_req_o(vf),
    .vfetch_addr_o(vaddr), .enter_o(ent), .handler_pc_o(hpc), .exc_num_o(exn), .handler_mode_o(hmode));
  nvc_core_model u_core (.mclk_i(mclk_i), .nrst_i(nrst_i), .dly_i(dly), .req_i({vf, pop, push}),
    .vfetch_addr_i(vaddr), .done_o(done), .vfetch_data_o(vdata));

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (ent === 1'b1) ent_cnt <= ent_cnt + 1;
    if (push === 1'b1) push_cnt <= push_cnt + 1;
    // Generous ceiling; the whole run needs a few hundred cycles
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge mclk_i);
    bus.rd <= 1'b0;
    #1 chk(n, rdata, e);
  endtask
  task automatic src(input int j);
    @(posedge mclk_i);
    irq <= nvc_pkg::nvc_irq_src_t'(24'h00_0001 << j);
    @(posedge mclk_i);
    irq <= '0;
  endtask
  task automatic wait_ent(input logic [5:0] vec);
    for (int i = 0; i < 60 && ent !== 1'b1; i++) @(posedge mclk_i) #1;
    chk("entered", 32'(ent), 32'h0000_0001);
    chk("vector", 32'(exn), 32'(vec));
    chk("handler_pc", hpc, 32'h0000_1000 + 32'(vec) * 4);
    chk("mode", 32'(hmode), 32'h0000_0001);
    @(posedge mclk_i);
  endtask
  task automatic ret();
    @(posedge mclk_i);
    exc_ret <= 1'b1;
    @(posedge mclk_i);
    exc_ret <= 1'b0;
  endtask
  task automatic ret_pop(input logic m);
    ret();
    for (int i = 0; i < 60 && pop !== 1'b1; i++) @(posedge mclk_i) #1;
    for (int i = 0; i < 60 && pop === 1'b1; i++) @(posedge mclk_i) #1;
    chk("mode_after_pop", 32'(hmode), 32'(m));
  endtask

  initial begin
    repeat (8) @(posedge mclk_i);
    nrst_i <= 1'b1;
    foreach (rows[k]) begin
      wr(rows[k].wa, rows[k].wd);
      rchk("reg_row", rows[k].ra, rows[k].ex);
    end
    chk("no_entry", 32'(ent_cnt), 32'h0000_0000);
    $display("test registers done");
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    foreach (rst_adr[k]) rchk("reset_value", rst_adr[k], 32'h0000_0000);
    $display("test reset done");
    for (int j = 23; j >= 0; j--) begin
      src(j);
      rchk("line_map", 32'hE000_E200, 32'h0000_0001 << line_of[j]);
      wr(32'hE000_E280, 32'hFFFF_FFFF);
    end
    $display("test line map done");
    wr(32'hE000_E100, 32'h0000_0001);
    src(23);
    wait_ent(6'h10);
    rchk("pend_cleared", 32'hE000_E200, 32'h0000_0000);
    wr(32'hE000_E200, 32'h0000_0001);
    wr(32'hE000_E280, 32'h0000_0001);
    rchk("still_active", 32'hE000_E300, 32'h0000_0001);
    ret_pop(1'b0);
    $display("test entry done");
    wr(32'hE000_E100, 32'h0000_0700);
    wr(32'hE000_E408, 32'h00C0_40C0);
    src(13);
    wait_ent(6'h18);
    src(14);
    wait_ent(6'h19);
    ret_pop(1'b1);
    chk("resumed", 32'(exn), 32'h0000_0018);
    c = ent_cnt;
    src(15);
    repeat (20) @(posedge mclk_i);
    chk("equal_no_preempt", 32'(ent_cnt), 32'(c));
    p = push_cnt;
    ret();
    wait_ent(6'h1A);
    chk("tail_no_push", 32'(push_cnt), 32'(p));
    ret_pop(1'b0);
    $display("test preempt done");
    dly <= 4'h6;
    src(13);
    for (int i = 0; i < 60 && push !== 1'b1; i++) @(posedge mclk_i) #1;
    @(posedge mclk_i);
    sysx.nmi <= 1'b1;
    @(posedge mclk_i);
    sysx.nmi <= 1'b0;
    wait_ent(6'h02);
    ret();
    wait_ent(6'h18);
    ret_pop(1'b0);
    dly <= 4'h0;
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk_i);
      sysx <= nvc_pkg::nvc_sys_exc_t'(5'h01 << k);
      @(posedge mclk_i);
      sysx <= '0;
      wait_ent(sys_vec[k]);
      ret_pop(1'b0);
    end
    $display("test late arrival and system done");
    summarize();
  end
endmodule
